// ---- iop_pin_board.sv ----
// Purpose: Board model of the port pins facing the bank.
// Assumes: External drive only where the bench enables it.
// Notes:   A pin nobody holds toggles each cycle, so stale levels show up.
`timescale 1ns/100ps
module iop_pin_board (
    input wire logic mclk_i,
    input wire iop_pkg::iop_pad_t [3:0] pads_i,
    input wire logic [3:0][7:0] ext_i,
    input wire logic [3:0][7:0] ext_en_i,
    output logic [3:0][7:0] level_o
);
    logic float_q = 1'b0;
    always_ff @(posedge mclk_i) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (pads_i[p].oe[b]) begin
                    level_o[p][b] = pads_i[p].out[b];
                end else if (ext_en_i[p][b]) begin
                    level_o[p][b] = ext_i[p][b];
                end else if (pads_i[p].pu[b]) begin
                    level_o[p][b] = 1'b1;
                end else begin
                    level_o[p][b] = float_q;
                end
            end
        end
    end
endmodule // iop_pin_board

// ---- iop_pkg.sv ----
// Purpose: Shared constants and types for the I/O port register bank.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Pad arrays are ordered port A, B, C, D (index 0 to 3).
package iop_pkg;

    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;

    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_PB_PIN = 8'h03;
    localparam logic [7:0] IDX_PB_DIR = 8'h04;
    localparam logic [7:0] IDX_PB_OUT = 8'h05;
    localparam logic [7:0] IDX_PC_PIN = 8'h06;
    localparam logic [7:0] IDX_PC_DIR = 8'h07;
    localparam logic [7:0] IDX_PC_OUT = 8'h08;
    localparam logic [7:0] IDX_PD_PIN = 8'h09;
    localparam logic [7:0] IDX_PD_DIR = 8'h0A;
    localparam logic [7:0] IDX_PD_OUT = 8'h0B;
    localparam logic [7:0] IDX_PA_PIN = 8'h0C;
    localparam logic [7:0] IDX_PA_DIR = 8'h0D;
    localparam logic [7:0] IDX_PA_OUT = 8'h0E;
    localparam logic [7:0] IDX_MCU_CTL = 8'h35;
    localparam logic [7:0] IDX_PORT_CTL = 8'h40;

    // Input-pin register index of each port, ordered A, B, C, D
    localparam logic [7:0] IDX_PORT_BASE [NUM_PORTS] =
        '{IDX_PA_PIN, IDX_PB_PIN, IDX_PC_PIN, IDX_PD_PIN};

    // Implemented pins per port; port A has pins 3:0 only
    localparam logic [7:0] PORT_MASK [NUM_PORTS] =
        '{8'h0F, 8'hFF, 8'hFF, 8'hFF};

    // Control register fields
    localparam int MCU_PUD_BIT = 4;
    localparam int MCU_BSC_BIT = 6;
    localparam int MCU_BSCE_BIT = 5;
    localparam logic [7:0] MCU_CTL_WMASK = 8'h70;
    localparam int PCTL_BBM_LSB = 4;
    localparam int PCTL_PUD_LSB = 0;

    // Values after reset
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RST_PIN = 8'h00;
    localparam logic [7:0] RST_MCU_CTL = 8'h00;
    localparam logic [7:0] RST_PORT_CTL = 8'h00;

    // Register kinds: three within a port group, one for the control words
    localparam logic [1:0] KIND_PIN = 2'h0;
    localparam logic [1:0] KIND_DIR = 2'h1;
    localparam logic [1:0] KIND_OUT = 2'h2;
    localparam logic [1:0] KIND_CTL = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write channel state, Gray along both arrival orders
    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_GOT_A = 2'b01,
        WS_RESP = 2'b11,
        WS_GOT_W = 2'b10
    } iop_wstate_t;

    typedef struct packed {
        logic hit;
        logic [1:0] port;
        logic [1:0] kind;
    } iop_sel_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } iop_pad_t;

endpackage

// ---- iop_port_bank.sv ----
// Purpose: Register bank of ports A to D with an AXI4-Lite slave.
// Assumes: Pin inputs are synchronous to mclk_i; one register per word.
// Notes:   Only byte lane 0 carries data; upper bits read as zero.
`timescale 1ns/100ps

module iop_port_bank #(
    parameter int ADDR_W = 10
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,

    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,

    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,

    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,

    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,

    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,

    // Pins, index 0 = port A ... 3 = port D
    input wire logic [3:0][7:0] pin_level_i,
    output iop_pkg::iop_pad_t [3:0] pads_o,

    // Stored brown-out sleep controls
    output logic bod_sleep_ctl_o,
    output logic bod_sleep_ctl_en_o
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Maps a byte address to a port and register kind
    function automatic iop_pkg::iop_sel_t decode(
        input logic [ADDR_W-1:0] addr
    );
        iop_pkg::iop_sel_t s;
        logic [7:0] idx;

        s = '0;
        idx = 8'(addr[ADDR_W-1:2]);
        // Three words per port: pins, direction, data
        for (int p = 0; p < iop_pkg::NUM_PORTS; p++) begin
            for (int k = 0; k < 3; k++) begin
                if (idx == iop_pkg::IDX_PORT_BASE[p] + 8'(k)) begin
                    s.hit = 1'b1;
                    s.port = 2'(p);
                    s.kind = 2'(k);
                end
            end
        end

        // Control words live outside the port groups
        if (idx == iop_pkg::IDX_MCU_CTL) begin
            s.hit = 1'b1;
            s.port = 2'h0;
            s.kind = iop_pkg::KIND_CTL;
        end else if (idx == iop_pkg::IDX_PORT_CTL) begin
            s.hit = 1'b1;
            s.port = 2'h1;
            s.kind = iop_pkg::KIND_CTL;
        end

        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] dir_q [4];
    logic [7:0] out_q [4];
    logic [7:0] pin_q [4];

    logic [7:0] mcu_ctl_q;
    logic [7:0] port_ctl_q;

    ////////////////////////////////////////////////////////////////////////
    // Write channel

    iop_pkg::iop_wstate_t wstate_q, wstate_d;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic [1:0] bresp_q;

    // A channel moves at an edge with valid and ready
    wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
    wire w_take = s_axi_wvalid_i & s_axi_wready_o;
    wire b_done = s_axi_bvalid_o & s_axi_bready_i;

    // Readies come from state only: no path from valid
    assign s_axi_awready_o = (wstate_q == iop_pkg::WS_IDLE) |
                             (wstate_q == iop_pkg::WS_GOT_W);
    assign s_axi_wready_o = (wstate_q == iop_pkg::WS_IDLE) |
                            (wstate_q == iop_pkg::WS_GOT_A);

    assign s_axi_bvalid_o = (wstate_q == iop_pkg::WS_RESP);
    assign s_axi_bresp_o = bresp_q;

    // Address and data of the write, whichever arrived first
    wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr_i : awaddr_q;
    wire [7:0] wr_data = w_take ? s_axi_wdata_i[7:0] : wdata_q;
    wire wr_strb0 = w_take ? s_axi_wstrb_i[0] : wstrb0_q;
    wire iop_pkg::iop_sel_t wsel = decode(wr_addr);

    always_comb begin
        wstate_d = wstate_q;
        case (wstate_q)
            iop_pkg::WS_IDLE: begin
                if (aw_take && w_take) begin
                    wstate_d = iop_pkg::WS_RESP;
                end else if (aw_take) begin
                    wstate_d = iop_pkg::WS_GOT_A;
                end else if (w_take) begin
                    wstate_d = iop_pkg::WS_GOT_W;
                end
            end

            iop_pkg::WS_GOT_A: begin
                if (w_take) begin
                    wstate_d = iop_pkg::WS_RESP;
                end
            end

            iop_pkg::WS_GOT_W: begin
                if (aw_take) begin
                    wstate_d = iop_pkg::WS_RESP;
                end
            end

            iop_pkg::WS_RESP: begin
                if (b_done) begin
                    wstate_d = iop_pkg::WS_IDLE;
                end
            end

            default: begin
                wstate_d = iop_pkg::WS_IDLE;
            end
        endcase
    end

    // The register update happens on the edge that completes the pair
    wire wr_fire = (wstate_d == iop_pkg::WS_RESP) &&
                   (wstate_q != iop_pkg::WS_RESP);
    // Lane 0 strobe low means no byte of the register is written
    wire wr_en = wr_fire & wsel.hit & wr_strb0;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wstate_q <= iop_pkg::WS_IDLE;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            bresp_q <= iop_pkg::RESP_OKAY;
        end else if (ce_i) begin
            wstate_q <= wstate_d;

            if (aw_take) begin
                awaddr_q <= s_axi_awaddr_i;
            end

            if (w_take) begin
                wdata_q <= s_axi_wdata_i[7:0];
                wstrb0_q <= s_axi_wstrb_i[0];
            end

            // Unmapped writes are answered, nothing changes
            if (wr_fire) begin
                bresp_q <= wsel.hit ? iop_pkg::RESP_OKAY
                                    : iop_pkg::RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port registers

    genvar gp;
    generate
        for (gp = 0; gp < iop_pkg::NUM_PORTS; gp++) begin : g_port
            // Port writes exclude the control words
            wire sel_port = wr_en & (wsel.port == 2'(gp)) &
                            (wsel.kind != iop_pkg::KIND_CTL);
            wire wr_dir = sel_port & (wsel.kind == iop_pkg::KIND_DIR);
            wire wr_out = sel_port & (wsel.kind == iop_pkg::KIND_OUT);
            wire pud_eff;

            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    dir_q[gp] <= iop_pkg::RST_DIR;
                    out_q[gp] <= iop_pkg::RST_OUT;
                    pin_q[gp] <= iop_pkg::RST_PIN;
                end else if (ce_i) begin
                    // Sample pins every cycle; writes never reach it
                    pin_q[gp] <= pin_level_i[gp] &
                                 iop_pkg::PORT_MASK[gp];

                    if (wr_dir) begin
                        dir_q[gp] <= wr_data &
                                     iop_pkg::PORT_MASK[gp];
                    end

                    if (wr_out) begin
                        out_q[gp] <= wr_data &
                                     iop_pkg::PORT_MASK[gp];
                    end
                end
            end

            // Port-wise disable ORed with the global disable
            assign pud_eff = port_ctl_q[iop_pkg::PCTL_PUD_LSB + gp] |
                             mcu_ctl_q[iop_pkg::MCU_PUD_BIT];

            // Pads follow the registers one edge later
            iop_port_pins #(
                .W(iop_pkg::PORT_W)
            ) u_pins (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .ce_i(ce_i),
                .dir_i(dir_q[gp]),
                .out_i(out_q[gp]),
                .pullup_off_i(pud_eff),
                .brk_before_mk_en_i(
                    port_ctl_q[iop_pkg::PCTL_BBM_LSB + gp]),
                .pad_o(pads_o[gp])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    wire wr_mcu = wr_en & (wsel.kind == iop_pkg::KIND_CTL) &
                  (wsel.port == 2'h0);

    wire wr_pctl = wr_en & (wsel.kind == iop_pkg::KIND_CTL) &
                   (wsel.port == 2'h1);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mcu_ctl_q <= iop_pkg::RST_MCU_CTL;
            port_ctl_q <= iop_pkg::RST_PORT_CTL;
        end else if (ce_i) begin
            // Reserved bits are dropped on the way in
            if (wr_mcu) begin
                mcu_ctl_q <= wr_data & iop_pkg::MCU_CTL_WMASK;
            end

            if (wr_pctl) begin
                port_ctl_q <= wr_data;
            end
        end
    end

    // Sleep bits are only stored here for the power logic
    assign bod_sleep_ctl_o = mcu_ctl_q[iop_pkg::MCU_BSC_BIT];
    assign bod_sleep_ctl_en_o = mcu_ctl_q[iop_pkg::MCU_BSCE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    logic rvalid_q;
    logic [7:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] rd_val;

    wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
    wire iop_pkg::iop_sel_t rsel = decode(s_axi_araddr_i);

    // One read in flight; a new address is taken only once data is gone
    assign s_axi_arready_o = ~rvalid_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = {24'h000000, rdata_q};
    assign s_axi_rresp_o = rresp_q;

    // Captured once at the address handshake
    always_comb begin
        rd_val = 8'h00;
        if (rsel.kind == iop_pkg::KIND_CTL) begin
            rd_val = (rsel.port == 2'h0) ? mcu_ctl_q : port_ctl_q;
        end else if (rsel.kind == iop_pkg::KIND_PIN) begin
            rd_val = pin_q[rsel.port];
        end else if (rsel.kind == iop_pkg::KIND_DIR) begin
            rd_val = dir_q[rsel.port];
        end else begin
            rd_val = out_q[rsel.port];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= iop_pkg::RESP_OKAY;
        end else if (ce_i) begin
            // Unmapped reads give zero data
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rsel.hit ? rd_val : 8'h00;
                rresp_q <= rsel.hit ? iop_pkg::RESP_OKAY
                                    : iop_pkg::RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

endmodule // iop_port_bank

// ---- iop_port_bank_assertions.sv ----
// Purpose: Port-level checks of the I/O port register bank.
// Assumes: One clock domain; reset disables every check.
// Notes:   The read index is captured at the read address handshake.
`timescale 1ns/100ps
module iop_port_bank_assertions #(
    parameter int ADDR_W = 10
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire iop_pkg::iop_pad_t [3:0] pads_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0] rd_idx_q;
    logic pu_clash;
    logic pu_no_out;
    wire logic rd_pa = rd_idx_q >= iop_pkg::IDX_PA_PIN &&
        rd_idx_q <= iop_pkg::IDX_PA_OUT;
    wire logic rd_map = (rd_idx_q >= iop_pkg::IDX_PB_PIN &&
        rd_idx_q <= iop_pkg::IDX_PA_OUT) ||
        rd_idx_q == iop_pkg::IDX_MCU_CTL || rd_idx_q == iop_pkg::IDX_PORT_CTL;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_idx_q <= 8'h00;
        end else if (s_axi_arvalid_i && s_axi_arready_o && ce_i) begin
            rd_idx_q <= 8'(s_axi_araddr_i >> 2);
        end
    end
    always_comb begin
        pu_clash = 1'b0;
        pu_no_out = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pu_clash |= |(pads_o[i].pu & pads_o[i].oe);
            pu_no_out |= |(pads_o[i].pu & ~pads_o[i].out);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence ar_taken_s;
        s_axi_arvalid_i && s_axi_arready_o && ce_i;
    endsequence
    sequence wr_taken_s;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
            s_axi_wready_o && ce_i;
    endsequence
    read_answer_a: assert property (ar_taken_s |=> s_axi_rvalid_o)
        else $error("read answer missing");
    write_answer_a: assert property (wr_taken_s |=> s_axi_bvalid_o)
        else $error("write answer missing");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    upper_zero_a: assert property (s_axi_rvalid_o |->
        s_axi_rdata_o[31:8] == 24'h000000 && (rd_map ||
        (s_axi_rresp_o == iop_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0)))
        else $error("bad read data or response");
    mcu_reserved_a: assert property (s_axi_rvalid_o &&
        rd_idx_q == iop_pkg::IDX_MCU_CTL |->
        s_axi_rdata_o[7] == 1'b0 && s_axi_rdata_o[3:0] == 4'h0)
        else $error("control reserved bits not zero");
    port_a_output_read_a: assert property (s_axi_rvalid_o && rd_pa |->
        s_axi_rdata_o[7:4] == 4'h0)
        else $error("port A upper bits not zero");
    port_a_output_pads_a: assert property ((pads_o[0].oe[7:4] |
        pads_o[0].pu[7:4]) == 4'h0)
        else $error("port A upper pads active");
    pullup_drive_a: assert property (!pu_clash && !pu_no_out)
        else $error("pull-up on a driven or low pin");
    arready_link_a: assert property (s_axi_arready_o == !s_axi_rvalid_o)
        else $error("read address ready while answering");
endmodule // iop_port_bank_assertions

bind iop_port_bank iop_port_bank_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .pads_o(pads_o));

// ---- iop_port_bank_bench.sv ----
// Purpose: Self-checking bench of the I/O port register bank.
// Assumes: AXI4-Lite master changes inputs just after rising edges.
// Notes:   Handshakes are judged mid-cycle, where every level is settled.
`timescale 1ns/100ps
module iop_port_bank_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] awaddr = 10'h000;
    logic [9:0] araddr = 10'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, bod, bod_en;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0][7:0] ext = 32'h0;
    logic [3:0][7:0] ext_en = 32'h0;
    logic [3:0][7:0] level;
    iop_pkg::iop_pad_t [3:0] pads;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #12.5 mclk = ~mclk;
    iop_port_bank u_iop_port_bank (.mclk_i(mclk), .rst_n_i(rst_n),
        .ce_i(1'b1), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .pin_level_i(level), .pads_o(pads),
        .bod_sleep_ctl_o(bod), .bod_sleep_ctl_en_o(bod_en));
    iop_pin_board u_iop_pin_board (.mclk_i(mclk), .pads_i(pads), .ext_i(ext),
        .ext_en_i(ext_en), .level_o(level));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d,
        input logic [1:0] er);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_t) begin
            @(negedge mclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            if (b_t) chk("bresp", 32'(bresp), 32'(er));
            @(posedge mclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
    endtask
    task automatic axi_rd(input logic [7:0] idx, input logic [7:0] exp,
        input logic [1:0] er);
        logic ar_t, r_t;
        r_t = 1'b0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_t) begin
            @(negedge mclk);
            ar_t = arvalid && arready;
            r_t = rvalid && rready;
            if (r_t) chk("rdata", rdata, {24'h000000, exp});
            if (r_t) chk("rresp", 32'(rresp), 32'(er));
            @(posedge mclk);
            if (ar_t) arvalid <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] base, m;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int p = 0; p < 4; p++) begin
            base = iop_pkg::IDX_PORT_BASE[p];
            axi_rd(base + 8'h01, 8'h00, iop_pkg::RESP_OKAY);
            axi_rd(base + 8'h02, 8'h00, iop_pkg::RESP_OKAY);
            chk("reset pads", 32'(pads[p]), 32'h0);
        end
        axi_rd(iop_pkg::IDX_MCU_CTL, 8'h00, iop_pkg::RESP_OKAY);
        // Pins held by the board while every pin is an input
        ext_en <= 32'hFFFFFFFF;
        ext <= {8'h3C, 8'hC3, 8'h5A, 8'hA5};
        repeat (2) @(posedge mclk);
        for (int p = 0; p < 4; p++) begin
            m = iop_pkg::PORT_MASK[p];
            axi_rd(iop_pkg::IDX_PORT_BASE[p], ext[p] & m, 2'h0);
        end
        axi_wr(iop_pkg::IDX_PB_PIN, 8'hFF, iop_pkg::RESP_OKAY);
        axi_rd(iop_pkg::IDX_PB_PIN, 8'h5A, iop_pkg::RESP_OKAY);
        ext_en <= 32'h0;
        for (int p = 0; p < 4; p++) begin
            base = iop_pkg::IDX_PORT_BASE[p];
            axi_wr(base + 8'h02, 8'hFF, iop_pkg::RESP_OKAY);
            axi_wr(base + 8'h01, 8'h96, iop_pkg::RESP_OKAY);
        end
        repeat (2) @(posedge mclk);
        for (int p = 0; p < 4; p++) begin
            base = iop_pkg::IDX_PORT_BASE[p];
            m = iop_pkg::PORT_MASK[p];
            axi_rd(base + 8'h01, 8'h96 & m, 2'h0);
            axi_rd(base + 8'h02, m, 2'h0);
            axi_rd(base, m, 2'h0);
            chk("oe", 32'(pads[p].oe), 32'(8'h96 & m));
            chk("pu", 32'(pads[p].pu), 32'(8'h69 & m));
        end
        axi_wr(iop_pkg::IDX_PORT_CTL, 8'h02, iop_pkg::RESP_OKAY);
        @(negedge mclk);
        chk("pu B port off", 32'(pads[1].pu), 32'h0);
        chk("pu C kept", 32'(pads[2].pu), 32'h69);
        @(posedge mclk);
        axi_wr(iop_pkg::IDX_PORT_CTL, 8'h00, iop_pkg::RESP_OKAY);
        axi_wr(iop_pkg::IDX_MCU_CTL, 8'hFF, iop_pkg::RESP_OKAY);
        axi_rd(iop_pkg::IDX_MCU_CTL, 8'h70, iop_pkg::RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            chk("pu global off", 32'(pads[p].pu), 32'h0);
        end
        chk("sleep ctl", 32'({bod, bod_en}), 32'h3);
        axi_wr(iop_pkg::IDX_MCU_CTL, 8'h00, iop_pkg::RESP_OKAY);
        @(negedge mclk);
        chk("pu back", 32'(pads[1].pu), 32'h69);
        @(posedge mclk);
        // Input to output with and without the tri-state step
        axi_wr(iop_pkg::IDX_PC_DIR, 8'h00, iop_pkg::RESP_OKAY);
        axi_wr(iop_pkg::IDX_PD_DIR, 8'h00, iop_pkg::RESP_OKAY);
        axi_wr(iop_pkg::IDX_PORT_CTL, 8'h40, iop_pkg::RESP_OKAY);
        axi_wr(iop_pkg::IDX_PC_DIR, 8'hFF, iop_pkg::RESP_OKAY);
        @(negedge mclk);
        chk("bbm oe step", 32'(pads[2].oe), 32'h0);
        @(negedge mclk);
        chk("bbm oe on", 32'(pads[2].oe), 32'hFF);
        @(posedge mclk);
        axi_wr(iop_pkg::IDX_PD_DIR, 8'hFF, iop_pkg::RESP_OKAY);
        @(negedge mclk);
        chk("plain oe", 32'(pads[3].oe), 32'hFF);
        @(posedge mclk);
        axi_wr(8'h20, 8'h55, iop_pkg::RESP_SLVERR);
        axi_rd(8'h20, 8'h00, iop_pkg::RESP_SLVERR);
        // Second reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("pads after reset", 32'(pads[2]), 32'h0);
        axi_rd(iop_pkg::IDX_PC_DIR, 8'h00, iop_pkg::RESP_OKAY);
        axi_rd(iop_pkg::IDX_PORT_CTL, 8'h00, iop_pkg::RESP_OKAY);
        report_and_stop();
    end
endmodule // iop_port_bank_bench

// ---- iop_port_pins.sv ----
// Purpose: Pad control of one port: drive, float, pull-up, break-before-make.
// Assumes: Register inputs are already masked to implemented pins.
// Notes:   Pad controls are registered, so they lag the registers by one edge.
`timescale 1ns/100ps
module iop_port_pins #(
    parameter int W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] dir_i,
    input wire logic [W-1:0] out_i,
    input wire logic pullup_off_i,
    input wire logic brk_before_mk_en_i,
    output iop_pkg::iop_pad_t pad_o
);

    logic [W-1:0] dir_prev_q;
    logic [W-1:0] oe_q, oe_d;
    logic [W-1:0] pu_q, pu_d;
    logic [W-1:0] dout_q;
    logic [W-1:0] new_out;

    // Pins that just turned to output while break-before-make is on
    assign new_out = dir_i & ~dir_prev_q & {W{brk_before_mk_en_i}};
    assign oe_d = dir_i & ~new_out;
    // Pull-up only on inputs with data one and no disable in force
    assign pu_d = ~dir_i & out_i & {W{~pullup_off_i}};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_prev_q <= '0;
            oe_q <= '0;
            pu_q <= '0;
            dout_q <= '0;
        end else if (ce_i) begin
            dir_prev_q <= dir_i;
            oe_q <= oe_d;
            pu_q <= pu_d;
            dout_q <= out_i;
        end
    end

    assign pad_o.out = 8'(dout_q);
    assign pad_o.oe = 8'(oe_q);
    assign pad_o.pu = 8'(pu_q);

endmodule // iop_port_pins
